// >>> inc/eeprom_pkg.sv
// Shared constants and types of the data EEPROM access logic.
// Assumes a single 100 MHz core clock; nothing else is needed by the importer.
package eeprom_pkg;

  // ===========================================================================
  // Geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 32;

  // ===========================================================================
  // Control register field positions
  localparam int CTRL_RSTART_POS  = 0;
  localparam int CTRL_RENABLE_POS = 1;
  localparam int CTRL_WSTART_POS  = 2;
  localparam int CTRL_WENABLE_POS = 3;

  // Control register layout, bit 3 down to bit 0
  typedef struct packed {
    logic write_enable_bit;
    logic write_start_bit;
    logic read_enable_bit;
    logic read_start_bit;
  } ctrl_bits_s;

  // ===========================================================================
  // Reset values
  localparam ctrl_bits_s          CTRL_RST = 4'h0;
  localparam logic [ADDR_W-1:0]   ADDR_RST = 5'h00;
  localparam logic [DATA_W-1:0]   DATA_RST = 8'h00;

  // ===========================================================================
  // Cycle timing at 100 MHz
  localparam int CLK_PERIOD_NS   = 10;
  localparam int READ_TIME_NS    = 40;
  localparam int READ_CYCLES     = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_DIV       = 16;
  localparam int WRITE_TICKS     = 64;

  typedef enum logic [1:0] {
    TMR_IDLE  = 2'b00,
    TMR_READ  = 2'b01,
    TMR_WRITE = 2'b10
  } tmr_state_e;

endpackage

// >>> logic/eeprom_access.sv
// Data EEPROM access control: address, data and control registers, the
// 32-byte array, completion flags and the multi-function vector request.
// Assumes software strobes arrive on I_CORE_CLK, one per instruction.
//
// Contract
// (R01) Read or write completion raises EEPROM request
// (R02) Forward only with both enables set
// (R03) Write end sets both request flags
// (R04) Vector needs all enables, stack not full
// (R05) Service clears multi-function flag only
// (R06) Write start must follow write enable directly
// (R07) Control register reached via pointer and bank
// (R08) Keep write enable and bank cleared
// (R09) Polled read sequence on read-start bit
// (R10) Polled write sequence on write-start bit
// (R11) Start bits self-clear when cycle ends
// (R12) Start ignored unless enable already set
// (R13) Never set both start bits together
// (R14) Write timed by independent internal timer
// (R15) Counted durations, completion resynchronised before use
`timescale 1ns/1ps
module eeprom_access #(
  parameter int READ_CYCLES = eeprom_pkg::READ_CYCLES,
  parameter int TIMER_DIV   = eeprom_pkg::TIMER_DIV,
  parameter int WRITE_TICKS = eeprom_pkg::WRITE_TICKS
) (
  input  wire logic                              I_CORE_CLK,
  input  wire logic                              I_RST_N,
  input  wire logic                              I_CTRL_WR,
  input  wire eeprom_pkg::ctrl_bits_s            I_CTRL_WDATA,
  input  wire logic                              I_ADDR_WR,
  input  wire logic [eeprom_pkg::ADDR_W-1:0]     I_ADDR_WDATA,
  input  wire logic                              I_DATA_WR,
  input  wire logic [eeprom_pkg::DATA_W-1:0]     I_DATA_WDATA,
  input  wire logic                              I_EEPROM_IRQ_ENABLE,
  input  wire logic                              I_MF_IRQ_ENABLE,
  input  wire logic                              I_GLOBAL_IRQ_ENABLE,
  input  wire logic                              I_STACK_FULL,
  input  wire logic                              I_IRQ_SERVICE,
  input  wire logic                              I_EEPROM_FLAG_CLR,
  output eeprom_pkg::ctrl_bits_s                 O_CTRL,
  output logic [eeprom_pkg::ADDR_W-1:0]          O_ADDR,
  output logic [eeprom_pkg::DATA_W-1:0]          O_DATA,
  output logic                                   O_EEPROM_IRQ_FLAG,
  output logic                                   O_MF_IRQ_FLAG,
  output logic                                   O_VECTOR_REQ
);

  eeprom_pkg::ctrl_bits_s         ctrl_q;
  logic [eeprom_pkg::ADDR_W-1:0]  addr_q;
  logic [eeprom_pkg::DATA_W-1:0]  data_q;
  logic [eeprom_pkg::DATA_W-1:0]  mem [eeprom_pkg::DEPTH];
  logic                           arm_q;
  logic                           busy_q;
  logic                           kind_wr_q;
  logic                           e2_flag_q;
  logic                           mf_flag_q;
  logic                           vec_q;
  logic                           done_tgl;
  logic                           sync1_q;
  logic                           sync2_q;
  logic                           sync3_q;
  logic                           done_evt;
  logic                           done_rd;
  logic                           done_wr;
  logic                           start_rd;
  logic                           start_wr;
  logic [15:0]                    busy_cnt_q;

  localparam int BUSY_LIMIT = TIMER_DIV * (WRITE_TICKS + 2) + READ_CYCLES + 8;

  // ===========================================================================
  // Start qualification: enables must already be set, both starts refused
  assign start_rd = I_CTRL_WR && I_CTRL_WDATA.read_start_bit && ctrl_q.read_enable_bit // R12
                    && !I_CTRL_WDATA.write_start_bit && !busy_q; // R13
  assign start_wr = I_CTRL_WR && I_CTRL_WDATA.write_start_bit && ctrl_q.write_enable_bit // R12
                    && arm_q // R06
                    && !I_CTRL_WDATA.read_start_bit && !busy_q; // R13

  // ===========================================================================
  // Completion crossing from the timer; first stage feeds only the second
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= done_tgl;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign done_evt = (sync2_q ^ sync3_q) && busy_q; // R15
  assign done_rd  = done_evt && !kind_wr_q;
  assign done_wr  = done_evt && kind_wr_q;

  eeprom_cycle_timer #(
    .READ_CYCLES (READ_CYCLES),
    .TIMER_DIV   (TIMER_DIV),
    .WRITE_TICKS (WRITE_TICKS)
  ) u_timer (
    .i_clk      (I_CORE_CLK),
    .i_rst_n    (I_RST_N),
    .i_start_rd (start_rd),
    .i_start_wr (start_wr),
    .o_done_tgl (done_tgl)
  );

  // ===========================================================================
  // Control register
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= eeprom_pkg::CTRL_RST;
    end else begin
      if (I_CTRL_WR) begin
        ctrl_q.write_enable_bit <= I_CTRL_WDATA.write_enable_bit;
        ctrl_q.read_enable_bit  <= I_CTRL_WDATA.read_enable_bit;
      end
      // A started cycle cannot be aborted, so start bits follow the cycle only
      if (done_wr) begin
        ctrl_q.write_start_bit <= 1'b0; // R11
      end else if (start_wr) begin
        ctrl_q.write_start_bit <= 1'b1;
      end
      if (done_rd) begin
        ctrl_q.read_start_bit <= 1'b0; // R11
      end else if (start_rd) begin
        ctrl_q.read_start_bit <= 1'b1;
      end
    end
  end

  // Write start is honoured only on the control write right after enabling
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arm_q <= 1'b0;
    end else if (I_CTRL_WR) begin
      arm_q <= I_CTRL_WDATA.write_enable_bit && !ctrl_q.write_enable_bit; // R06
    end
  end

  // ===========================================================================
  // Cycle tracking
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      busy_q    <= 1'b0;
      kind_wr_q <= 1'b0;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end else if (start_rd || start_wr) begin
      busy_q    <= 1'b1;
      kind_wr_q <= start_wr;
    end
  end

  // ===========================================================================
  // Address and data registers, array
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr_q <= eeprom_pkg::ADDR_RST;
    end else if (I_ADDR_WR && !busy_q) begin
      addr_q <= I_ADDR_WDATA;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_q <= eeprom_pkg::DATA_RST;
    end else if (done_rd) begin
      data_q <= mem[addr_q];
    end else if (I_DATA_WR && !busy_q) begin
      data_q <= I_DATA_WDATA;
    end
  end

  // Non-volatile contents: no reset
  always_ff @(posedge I_CORE_CLK) begin
    if (done_wr) begin
      mem[addr_q] <= data_q;
    end
  end

  // ===========================================================================
  // Request flags; a completion wins over a clear in the same cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      e2_flag_q <= 1'b0;
    end else if (done_evt) begin
      e2_flag_q <= 1'b1; // R01
    end else if (I_EEPROM_FLAG_CLR) begin
      e2_flag_q <= 1'b0; // R05
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mf_flag_q <= 1'b0;
    end else if (done_evt) begin
      mf_flag_q <= 1'b1; // R03
    end else if (I_IRQ_SERVICE) begin
      mf_flag_q <= 1'b0; // R05
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      vec_q <= 1'b0;
    end else begin
      vec_q <= mf_flag_q && I_EEPROM_IRQ_ENABLE && I_MF_IRQ_ENABLE // R02
               && I_GLOBAL_IRQ_ENABLE && !I_STACK_FULL && !I_IRQ_SERVICE; // R04
    end
  end

  // Watch length of a busy cycle for the bound below
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      busy_cnt_q <= 16'h0000;
    end else if (!busy_q) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end

  assign O_CTRL            = ctrl_q;
  assign O_ADDR            = addr_q;
  assign O_DATA            = data_q;
  assign O_EEPROM_IRQ_FLAG = e2_flag_q;
  assign O_MF_IRQ_FLAG     = mf_flag_q;
  assign O_VECTOR_REQ      = vec_q;

  // ===========================================================================
  // Assertions
  sequence s_wr_refused;
    I_CTRL_WR && I_CTRL_WDATA.write_start_bit && !ctrl_q.write_enable_bit && !ctrl_q.write_start_bit;
  endsequence

  sequence s_done_seen;
    done_evt ##1 (e2_flag_q && mf_flag_q);
  endsequence

  AST_WSTART_NEEDS_EN: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R12
    s_wr_refused |=> !ctrl_q.write_start_bit)
    else $error("write start taken without write enable");

  AST_WSTART_NEEDS_ARM: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R06
    $rose(ctrl_q.write_start_bit) |-> $past(arm_q))
    else $error("write start without preceding enable write");

  AST_DONE_FLAGS: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R01
    done_evt |-> s_done_seen)
    else $error("completion did not raise both flags");

  AST_WR_END_FLAGS: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R03
    $fell(ctrl_q.write_start_bit) |-> e2_flag_q && mf_flag_q)
    else $error("write end without request flags");

  AST_START_SELF_CLR: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R11
    (busy_q && done_evt) |=> !ctrl_q.write_start_bit && !ctrl_q.read_start_bit && !busy_q)
    else $error("start bit not cleared at completion");

  AST_SERVICE_CLR: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R05
    (I_IRQ_SERVICE && !done_evt && e2_flag_q && !I_EEPROM_FLAG_CLR) |=> !mf_flag_q && e2_flag_q)
    else $error("service cleared wrong flag");

  AST_VECTOR_GATE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R04
    O_VECTOR_REQ |-> $past(I_EEPROM_IRQ_ENABLE && I_MF_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE
                           && !I_STACK_FULL && mf_flag_q))
    else $error("vector request without all enables");

  AST_NO_DUAL_START: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R13
    !(ctrl_q.write_start_bit && ctrl_q.read_start_bit))
    else $error("both start bits set");

  AST_BUSY_BOUND: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R14
    busy_q |-> busy_cnt_q <= 16'(BUSY_LIMIT))
    else $error("cycle exceeded its timer bound");

endmodule // eeprom_access

// >>> logic/eeprom_cycle_timer.sv
// Cycle timer for EEPROM byte reads and writes.
// Assumes one start pulse at a time; the write is paced by a free-running
// divided tick unrelated to the start, so its length varies by a tick.
`timescale 1ns/1ps
module eeprom_cycle_timer #(
  parameter int READ_CYCLES = eeprom_pkg::READ_CYCLES,
  parameter int TIMER_DIV   = eeprom_pkg::TIMER_DIV,
  parameter int WRITE_TICKS = eeprom_pkg::WRITE_TICKS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start_rd,
  input  wire logic i_start_wr,
  output logic      o_done_tgl
);

  logic [15:0]            div_q;
  logic                   tick;
  logic [15:0]            cnt_q;
  eeprom_pkg::tmr_state_e state_q;

  // ===========================================================================
  // Free-running write timer tick, not aligned to any start
  assign tick = (div_q == 16'(TIMER_DIV - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ===========================================================================
  // Cycle sequencing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= eeprom_pkg::TMR_IDLE;
      cnt_q      <= 16'h0000;
      o_done_tgl <= 1'b0;
    end else begin
      case (state_q)
        eeprom_pkg::TMR_IDLE: begin
          if (i_start_rd) begin
            state_q <= eeprom_pkg::TMR_READ;
            cnt_q   <= 16'(READ_CYCLES);
          end else if (i_start_wr) begin
            state_q <= eeprom_pkg::TMR_WRITE; // R14
            cnt_q   <= 16'(WRITE_TICKS);
          end
        end
        eeprom_pkg::TMR_READ: begin
          if (cnt_q <= 16'h0001) begin
            state_q    <= eeprom_pkg::TMR_IDLE;
            o_done_tgl <= ~o_done_tgl;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        eeprom_pkg::TMR_WRITE: begin
          if (tick) begin
            if (cnt_q <= 16'h0001) begin
              state_q    <= eeprom_pkg::TMR_IDLE;
              o_done_tgl <= ~o_done_tgl; // R15
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
        end
        default: begin
          state_q <= eeprom_pkg::TMR_IDLE;
        end
      endcase
    end
  end

endmodule // eeprom_cycle_timer

// >>> sim/tb_eeprom_access.sv
// Self-checking bench for the data EEPROM access control block.
// Assumes eeprom_pkg is compiled first; drives every port of the block itself.
`timescale 1ns/1ps
module tb_eeprom_access;
  // ===========================================================================
  // Signals and clock
  localparam int LIMIT = 20000;
  logic                               I_CORE_CLK = 1'b0;
  logic                               I_RST_N = 1'b0;
  logic                               I_CTRL_WR = 1'b0;
  eeprom_pkg::ctrl_bits_s             I_CTRL_WDATA = 4'h0;
  logic                               I_ADDR_WR = 1'b0;
  logic [eeprom_pkg::ADDR_W-1:0]      I_ADDR_WDATA = 5'h00;
  logic                               I_DATA_WR = 1'b0;
  logic [eeprom_pkg::DATA_W-1:0]      I_DATA_WDATA = 8'h00;
  logic                               I_EEPROM_IRQ_ENABLE = 1'b0;
  logic                               I_MF_IRQ_ENABLE = 1'b0;
  logic                               I_GLOBAL_IRQ_ENABLE = 1'b0;
  logic                               I_STACK_FULL = 1'b0;
  logic                               I_IRQ_SERVICE = 1'b0;
  logic                               I_EEPROM_FLAG_CLR = 1'b0;
  eeprom_pkg::ctrl_bits_s             O_CTRL;
  logic [eeprom_pkg::ADDR_W-1:0]      O_ADDR;
  logic [eeprom_pkg::DATA_W-1:0]      O_DATA;
  logic                               O_EEPROM_IRQ_FLAG;
  logic                               O_MF_IRQ_FLAG;
  logic                               O_VECTOR_REQ;
  int                                 n_fail = 0;
  int                                 checks = 0;
  int                                 cyc = 0;

  always #5 I_CORE_CLK = ~I_CORE_CLK;

  // Short timer settings keep each write to about ten cycles
  eeprom_access #(.READ_CYCLES(4), .TIMER_DIV(2), .WRITE_TICKS(4)) i_dut (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_CTRL_WR(I_CTRL_WR), .I_CTRL_WDATA(I_CTRL_WDATA),
    .I_ADDR_WR(I_ADDR_WR), .I_ADDR_WDATA(I_ADDR_WDATA), .I_DATA_WR(I_DATA_WR), .I_DATA_WDATA(I_DATA_WDATA),
    .I_EEPROM_IRQ_ENABLE(I_EEPROM_IRQ_ENABLE), .I_MF_IRQ_ENABLE(I_MF_IRQ_ENABLE),
    .I_GLOBAL_IRQ_ENABLE(I_GLOBAL_IRQ_ENABLE), .I_STACK_FULL(I_STACK_FULL), .I_IRQ_SERVICE(I_IRQ_SERVICE),
    .I_EEPROM_FLAG_CLR(I_EEPROM_FLAG_CLR), .O_CTRL(O_CTRL), .O_ADDR(O_ADDR), .O_DATA(O_DATA),
    .O_EEPROM_IRQ_FLAG(O_EEPROM_IRQ_FLAG), .O_MF_IRQ_FLAG(O_MF_IRQ_FLAG), .O_VECTOR_REQ(O_VECTOR_REQ));

  // ===========================================================================
  // Reporting
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A hang counts as a mismatch and still reaches the verdict
  always @(posedge I_CORE_CLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  // ===========================================================================
  // Access tasks: one strobe per instruction, output settles one edge later
  task automatic settle();
    @(posedge I_CORE_CLK);
    #1;
  endtask

  task automatic ctrl_wr(input eeprom_pkg::ctrl_bits_s v);
    @(posedge I_CORE_CLK);
    I_CTRL_WR    <= 1'b1;
    I_CTRL_WDATA <= v;
    @(posedge I_CORE_CLK);
    I_CTRL_WR    <= 1'b0;
  endtask

  task automatic addr_data_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge I_CORE_CLK);
    I_ADDR_WR    <= 1'b1;
    I_ADDR_WDATA <= a;
    I_DATA_WR    <= 1'b1;
    I_DATA_WDATA <= d;
    @(posedge I_CORE_CLK);
    I_ADDR_WR    <= 1'b0;
    I_DATA_WR    <= 1'b0;
  endtask

  task automatic pulse_clear(input logic svc, input logic clr);
    @(posedge I_CORE_CLK);
    I_IRQ_SERVICE     <= svc;
    I_EEPROM_FLAG_CLR <= clr;
    @(posedge I_CORE_CLK);
    I_IRQ_SERVICE     <= 1'b0;
    I_EEPROM_FLAG_CLR <= 1'b0;
    settle();
  endtask

  // Bounded poll of a start bit, as software would do
  task automatic wait_clear(input int pos);
    int n;
    n = 0;
    while (O_CTRL[pos] !== 1'b0 && n < 400) begin
      settle();
      n++;
    end
    check("start bit self clear", {7'h00, O_CTRL[pos]}, 8'h00);
  endtask

  task automatic do_write(input logic [4:0] a, input logic [7:0] d);
    addr_data_wr(a, d);
    ctrl_wr(4'h8);
    ctrl_wr(4'hC);
    settle();
    check("write start taken", {4'h0, O_CTRL}, 8'h0C);
    wait_clear(eeprom_pkg::CTRL_WSTART_POS);
    check("ctrl after write", {4'h0, O_CTRL}, 8'h08);
    check("eeprom flag after write", {7'h00, O_EEPROM_IRQ_FLAG}, 8'h01);
    check("mf flag after write", {7'h00, O_MF_IRQ_FLAG}, 8'h01);
    ctrl_wr(4'h0);
  endtask

  task automatic do_read(input logic [4:0] a, input logic [7:0] exp);
    addr_data_wr(a, 8'h00);
    ctrl_wr(4'h2);
    ctrl_wr(4'h3);
    // The readback moves on the strobe's own edge, so look one edge later
    settle();
    check("read start taken", {4'h0, O_CTRL}, 8'h03);
    wait_clear(eeprom_pkg::CTRL_RSTART_POS);
    check("read data", O_DATA, exp);
    check("addr kept", {3'h0, O_ADDR}, {3'h0, a});
    check("eeprom flag after read", {7'h00, O_EEPROM_IRQ_FLAG}, 8'h01);
    check("mf flag after read", {7'h00, O_MF_IRQ_FLAG}, 8'h01);
    ctrl_wr(4'h0);
  endtask

  // ===========================================================================
  // Tests
  initial begin
    eeprom_pkg::ctrl_bits_s bad [0:4];
    eeprom_pkg::ctrl_bits_s keep [0:4];
    logic [3:0] en;
    repeat (12) @(posedge I_CORE_CLK);
    I_RST_N <= 1'b1;
    settle();
    check("ctrl reset", {4'h0, O_CTRL}, 8'h00);
    check("addr reset", {3'h0, O_ADDR}, 8'h00);
    check("data reset", O_DATA, 8'h00);
    check("flags reset", {5'h00, O_EEPROM_IRQ_FLAG, O_MF_IRQ_FLAG, O_VECTOR_REQ}, 8'h00);
    $display("test reset finished");

    // Starts without a prior enable, without a fresh enable, or both at once
    bad  = '{4'h4, 4'h1, 4'h8, 4'hC, 4'hF};
    keep = '{4'h0, 4'h0, 4'h8, 4'h8, 4'hA};
    for (int i = 0; i < 5; i++) begin
      // A repeated enable write disarms the start that follows
      if (i == 3)
        ctrl_wr(4'h8);
      if (i == 4)
        ctrl_wr(4'hA);
      ctrl_wr(bad[i]);
      settle();
      check("refused start", {4'h0, O_CTRL}, {4'h0, keep[i]});
    end
    repeat (20) settle();
    check("no cycle after refusal", {6'h00, O_EEPROM_IRQ_FLAG, O_MF_IRQ_FLAG}, 8'h00);
    ctrl_wr(4'h0);
    $display("test refusal finished");

    do_write(5'h0A, 8'hA5);
    pulse_clear(1'b1, 1'b1);
    do_write(5'h1F, 8'h3C);
    do_read(5'h0A, 8'hA5);
    do_read(5'h1F, 8'h3C);
    $display("test write read finished");

    // Service clears only the shared flag
    pulse_clear(1'b1, 1'b0);
    check("mf flag after service", {7'h00, O_MF_IRQ_FLAG}, 8'h00);
    check("eeprom flag kept", {7'h00, O_EEPROM_IRQ_FLAG}, 8'h01);
    pulse_clear(1'b0, 1'b1);
    check("eeprom flag cleared", {7'h00, O_EEPROM_IRQ_FLAG}, 8'h00);
    do_read(5'h0A, 8'hA5);
    for (int i = 0; i < 16; i++) begin
      en = 4'(i);
      @(posedge I_CORE_CLK);
      I_GLOBAL_IRQ_ENABLE <= en[0];
      I_EEPROM_IRQ_ENABLE <= en[1];
      I_MF_IRQ_ENABLE     <= en[2];
      I_STACK_FULL        <= en[3];
      settle();
      settle();
      check("vector request", {7'h00, O_VECTOR_REQ}, {7'h00, (en == 4'h7)});
    end
    // Free the stack so the service pulse is what drops the request
    @(posedge I_CORE_CLK);
    I_STACK_FULL <= 1'b0;
    settle();
    settle();
    check("vector before service", {7'h00, O_VECTOR_REQ}, 8'h01);
    pulse_clear(1'b1, 1'b0);
    settle();
    check("vector after service", {7'h00, O_VECTOR_REQ}, 8'h00);
    check("eeprom flag after service", {7'h00, O_EEPROM_IRQ_FLAG}, 8'h01);
    $display("test interrupt finished");
    conclude();
  end
endmodule // tb_eeprom_access
